// ---- logic/touch_adc_pkg.sv ----
// constants, types and helpers for the touch digitizer control word decoder
`default_nettype none
package touch_adc_pkg;
    localparam int          START_POS     = 7;
    localparam int          CHAN_MSB      = 6;
    localparam int          CHAN_LSB      = 4;
    localparam int          MODE_POS      = 3;
    localparam int          REF_POS       = 2;
    localparam int          PD_UPPER_POS  = 1;
    localparam int          PD_LOWER_POS  = 0;
    localparam logic [2:0]  RST_CHANNEL   = 3'h0;
    localparam logic        RST_RES_8BIT  = 1'h0;
    localparam logic        RST_REF_KIND  = 1'h1;
    localparam logic        RST_PD_UPPER  = 1'h1;
    localparam logic        RST_PD_LOWER  = 1'h0;
    localparam logic [2:0]  WORD_LAST     = 3'h7;
    localparam logic [4:0]  WORD_RISES    = 5'h08;
    localparam logic [4:0]  WAKE_FALL     = 5'h04;
    localparam logic [4:0]  TRACK_FALL    = 5'h05;
    localparam logic [4:0]  HOLD_FALL     = 5'h08;
    localparam logic [4:0]  END_FALL_12   = 5'h14;
    localparam logic [4:0]  END_FALL_8    = 5'h10;
    localparam logic [4:0]  GUARD_12      = 5'h0F;
    localparam logic [4:0]  GUARD_8       = 5'h0B;
    localparam logic [4:0]  CNT_MAX       = 5'h1F;
    localparam logic [2:0]  CHAN_STAGE    = 3'h4;
    localparam logic [2:0]  REF_STAGE     = 3'h6;

    typedef struct packed {
        logic       start;
        logic [2:0] channel_code;
        logic       res_8bit;
        logic       reference_kind;
        logic       power_ctl_upper;
        logic       power_ctl_lower;
    } ctrl_word_t;

    typedef enum logic [2:0] {
        SEL_NONE  = 3'b000,
        SEL_XPOS  = 3'b001,
        SEL_YPOS  = 3'b010,
        SEL_AUX3  = 3'b011,
        SEL_AUX4  = 3'b100,
        SEL_IDENT = 3'b101
    } analog_sel_t;

    typedef struct packed {
        analog_sel_t sel;
        logic        x_drv;
        logic        y_drv;
        logic        ref_across_drv;
        logic        invalid;
    } route_t;

    typedef enum logic {
        W_HUNT    = 1'b0,
        W_CAPTURE = 1'b1
    } word_state_t;

    localparam ctrl_word_t RST_CONFIG = '{start: 1'h0, channel_code: RST_CHANNEL,
        res_8bit: RST_RES_8BIT, reference_kind: RST_REF_KIND,
        power_ctl_upper: RST_PD_UPPER, power_ctl_lower: RST_PD_LOWER};

    function automatic ctrl_word_t unpack_word(input logic [7:0] w);
        ctrl_word_t c;
        c.start           = w[START_POS];
        c.channel_code    = w[CHAN_MSB:CHAN_LSB];
        c.res_8bit        = w[MODE_POS];
        c.reference_kind  = w[REF_POS];
        c.power_ctl_upper = w[PD_UPPER_POS];
        c.power_ctl_lower = w[PD_LOWER_POS];
        return c;
    endfunction : unpack_word

    function automatic logic [4:0] end_fall(input logic res_8bit);
        return res_8bit ? END_FALL_8 : END_FALL_12;
    endfunction : end_fall

    function automatic logic [4:0] guard_rises(input logic res_8bit);
        return res_8bit ? GUARD_8 : GUARD_12;
    endfunction : guard_rises
endpackage : touch_adc_pkg
`default_nettype wire

// ---- logic/touch_channel_decode.sv ----
// channel, driver and reference decode of the control word
`default_nettype none
module touch_channel_decode (
    input  wire touch_adc_pkg::ctrl_word_t cfg,
    output touch_adc_pkg::route_t          route
);
    import touch_adc_pkg::*;

    always_comb begin
        route = '{sel: SEL_NONE, x_drv: 1'b0, y_drv: 1'b0,
                  ref_across_drv: 1'b0, invalid: 1'b1};
        case ({cfg.channel_code, cfg.reference_kind})
            4'b0011: begin
                route.sel     = SEL_XPOS;
                route.y_drv   = 1'b1;
                route.invalid = 1'b0;
            end
            4'b0101: begin
                route.sel     = SEL_AUX3;
                route.invalid = 1'b0;
            end
            4'b1011: begin
                route.sel     = SEL_YPOS;
                route.x_drv   = 1'b1;
                route.invalid = 1'b0;
            end
            4'b1101: begin
                route.sel     = SEL_AUX4;
                route.invalid = 1'b0;
            end
            4'b0010: begin
                route.sel            = SEL_XPOS;
                route.y_drv          = 1'b1;
                route.ref_across_drv = 1'b1;
                route.invalid        = 1'b0;
            end
            4'b1010: begin
                route.sel            = SEL_YPOS;
                route.x_drv          = 1'b1;
                route.ref_across_drv = 1'b1;
                route.invalid        = 1'b0;
            end
            4'b1100: begin
                route.sel     = SEL_IDENT;
                route.invalid = 1'b0;
            end
            default: begin
                route.invalid = 1'b1;
            end
        endcase
    end
endmodule : touch_channel_decode
`default_nettype wire

// ---- logic/touch_adc_control_word.sv ----
// control word capture, conversion sequencing and power management
`default_nettype none
module touch_adc_control_word (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic                      chip_select_n,
    input  wire logic                      serial_clock,
    input  wire logic                      serial_data_in,
    output touch_adc_pkg::ctrl_word_t      active_config,
    output touch_adc_pkg::route_t          route,
    output logic                           word_strobe,
    output logic                           powered,
    output logic                           tracking,
    output logic                           hold_strobe,
    output logic                           converting,
    output logic                           conversion_done,
    output logic                           x_drivers_on,
    output logic                           y_drivers_on,
    output logic                           y_bottom_on,
    output logic                           pen_touch_irq_enable
);
    import touch_adc_pkg::*;

    word_state_t word_state_reg;
    word_state_t word_state_next;
    logic [7:0]  stage_reg;
    logic [7:0]  stage_next;
    logic [2:0]  bit_cnt_reg;
    logic [2:0]  bit_cnt_next;
    logic [4:0]  wfall_reg;
    logic [4:0]  wfall_next;
    ctrl_word_t  cfg_reg;
    ctrl_word_t  cfg_next;
    logic        conv_reg;
    logic        conv_next;
    logic [4:0]  crise_reg;
    logic [4:0]  crise_next;
    logic [4:0]  cfall_reg;
    logic [4:0]  cfall_next;
    logic        hold_drv_reg;
    logic        hold_drv_next;
    logic        strobe_reg;
    logic        strobe_next;
    logic        hold_reg;
    logic        hold_next;
    logic        done_reg;
    logic        done_next;
    logic        sclk_prev_reg;
    logic        selected;
    logic        rise;
    logic        fall;
    logic        guard_ok;
    logic        word_end;
    ctrl_word_t  staged;
    ctrl_word_t  new_word;

    assign selected = !chip_select_n;
    assign rise     = selected && serial_clock && !sclk_prev_reg;
    assign fall     = selected && !serial_clock && sclk_prev_reg;
    assign guard_ok = !conv_reg || (crise_reg >= guard_rises(cfg_reg.res_8bit));
    assign word_end = (word_state_reg == W_CAPTURE) && rise && (bit_cnt_reg == WORD_LAST);
    assign new_word = unpack_word({stage_reg[7:1], serial_data_in});

    always_comb begin
        word_state_next = word_state_reg;
        stage_next      = stage_reg;
        bit_cnt_next    = bit_cnt_reg;
        wfall_next      = wfall_reg;
        case (word_state_reg)
            W_HUNT: begin
                if (rise && serial_data_in && guard_ok) begin
                    word_state_next = W_CAPTURE;
                    stage_next      = 8'h80;
                    bit_cnt_next    = 3'h1;
                    wfall_next      = 5'h00;
                end
            end
            W_CAPTURE: begin
                if (rise) begin
                    stage_next[3'h7 - bit_cnt_reg] = serial_data_in;
                    bit_cnt_next = bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == WORD_LAST) begin
                        word_state_next = W_HUNT;
                        bit_cnt_next    = 3'h0;
                    end
                end
                if (fall && (wfall_reg != CNT_MAX)) begin
                    wfall_next = wfall_reg + 5'h01;
                end
            end
            default: begin
                word_state_next = W_HUNT;
            end
        endcase
        if (!selected) begin
            word_state_next = W_HUNT;
            bit_cnt_next    = 3'h0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            word_state_reg <= W_HUNT;
            stage_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            wfall_reg      <= 5'h00;
            sclk_prev_reg  <= 1'b0;
        end else begin
            word_state_reg <= word_state_next;
            stage_reg      <= stage_next;
            bit_cnt_reg    <= bit_cnt_next;
            wfall_reg      <= wfall_next;
            sclk_prev_reg  <= serial_clock;
        end
    end

    always_comb begin
        cfg_next      = cfg_reg;
        conv_next     = conv_reg;
        crise_next    = crise_reg;
        cfall_next    = cfall_reg;
        hold_drv_next = hold_drv_reg;
        strobe_next   = 1'b0;
        hold_next     = 1'b0;
        done_next     = 1'b0;
        if (conv_reg && rise && (crise_reg != CNT_MAX)) begin
            crise_next = crise_reg + 5'h01;
        end
        if (conv_reg && fall) begin
            cfall_next = cfall_reg + 5'h01;
            if (cfall_next == HOLD_FALL) begin
                hold_next = 1'b1;
            end
            if (cfall_next == end_fall(cfg_reg.res_8bit)) begin
                conv_next     = 1'b0;
                done_next     = 1'b1;
                hold_drv_next = cfg_reg.power_ctl_upper && cfg_reg.power_ctl_lower;
            end
        end
        if (word_end) begin
            cfg_next    = new_word;
            strobe_next = 1'b1;
            conv_next   = 1'b1;
            crise_next  = WORD_RISES;
            cfall_next  = wfall_reg;
            if ({new_word.channel_code, new_word.reference_kind,
                 new_word.power_ctl_upper, new_word.power_ctl_lower} !=
                {cfg_reg.channel_code, cfg_reg.reference_kind,
                 cfg_reg.power_ctl_upper, cfg_reg.power_ctl_lower}) begin
                hold_drv_next = 1'b0;
            end
        end
        if (!selected) begin
            conv_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_reg      <= RST_CONFIG;
            conv_reg     <= 1'b0;
            crise_reg    <= 5'h00;
            cfall_reg    <= 5'h00;
            hold_drv_reg <= 1'b0;
            strobe_reg   <= 1'b0;
            hold_reg     <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            conv_reg     <= conv_next;
            crise_reg    <= crise_next;
            cfall_reg    <= cfall_next;
            hold_drv_reg <= hold_drv_next;
            strobe_reg   <= strobe_next;
            hold_reg     <= hold_next;
            done_reg     <= done_next;
        end
    end

    // channel and reference take effect as soon as their last bit has arrived, before the word ends
    always_comb begin
        staged = cfg_reg;
        if ((word_state_reg == W_CAPTURE) && (bit_cnt_reg >= CHAN_STAGE)) begin
            staged.channel_code = stage_reg[CHAN_MSB:CHAN_LSB];
        end
        if ((word_state_reg == W_CAPTURE) && (bit_cnt_reg >= REF_STAGE)) begin
            staged.reference_kind = stage_reg[REF_POS];
        end
    end

    touch_channel_decode u_decode (
        .cfg   (staged),
        .route (route)
    );

    assign active_config   = cfg_reg;
    assign word_strobe     = strobe_reg;
    assign hold_strobe     = hold_reg;
    assign conversion_done = done_reg;
    assign converting      = conv_reg && (cfall_reg >= HOLD_FALL);
    assign tracking        = ((word_state_reg == W_CAPTURE) && (wfall_reg >= TRACK_FALL))
                           || (conv_reg && (cfall_reg < HOLD_FALL));
    assign powered         = cfg_reg.power_ctl_upper || conv_reg
                           || ((word_state_reg == W_CAPTURE) && (wfall_reg >= WAKE_FALL));
    assign x_drivers_on    = route.x_drv && (tracking || hold_drv_reg
                           || (converting && !staged.reference_kind));
    assign y_drivers_on    = route.y_drv && (tracking || hold_drv_reg
                           || (converting && !staged.reference_kind));
    assign y_bottom_on     = !powered && !cfg_reg.power_ctl_lower;
    assign pen_touch_irq_enable = !cfg_reg.power_ctl_lower;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_start_seen;
        (word_state_reg == W_HUNT) && rise && serial_data_in && guard_ok;
    endsequence

    sequence s_fifth_fall;
        (word_state_reg == W_CAPTURE) && fall && (wfall_reg == TRACK_FALL - 5'h01);
    endsequence

    a_hunt_ignores: assert property (
        ((word_state_reg == W_HUNT) && !(rise && serial_data_in))
        |=> (word_state_reg == W_HUNT) && $stable(cfg_reg))
        else $error("input taken without start bit");

    a_start_capture: assert property (
        s_start_seen ##1 (!rise && selected) [*1] |-> (word_state_reg == W_CAPTURE))
        else $error("start bit not accepted");

    a_word_latched: assert property (
        word_end |=> strobe_reg && (cfg_reg == $past(new_word)))
        else $error("control word not latched");

    a_settings_hold: assert property (
        !word_end |=> $stable(cfg_reg))
        else $error("settings changed without a word");

    a_guard_12: assert property (
        ((word_state_reg == W_HUNT) && conv_reg && !cfg_reg.res_8bit
         && (crise_reg < GUARD_12) && rise)
        |=> (word_state_reg == W_HUNT))
        else $error("start accepted too early");

    a_wake_fourth: assert property (
        ((word_state_reg == W_CAPTURE) && fall && (wfall_reg == WAKE_FALL - 5'h01)
         && selected) |=> powered)
        else $error("no wake on fourth falling edge");

    a_track_window: assert property (
        s_fifth_fall |=> tracking)
        else $error("tracking not entered");

    a_hold_edge: assert property (
        (conv_reg && fall && (cfall_reg == HOLD_FALL - 5'h01))
        |=> hold_strobe && !tracking ##1 !hold_strobe)
        else $error("hold edge wrong");

    a_sleep_end: assert property (
        (conv_reg && fall && (cfall_reg + 5'h01 == end_fall(cfg_reg.res_8bit))
         && !cfg_reg.power_ctl_upper && (word_state_reg == W_HUNT))
        |=> conversion_done && !powered && (y_bottom_on == !cfg_reg.power_ctl_lower))
        else $error("no power down at conversion end");

    a_perm_power: assert property (
        cfg_reg.power_ctl_upper |-> powered)
        else $error("permanent power dropped");

    a_ident_code: assert property (
        ((staged.channel_code == 3'h6) && !staged.reference_kind)
        |-> (route.sel == SEL_IDENT) && !x_drivers_on && !y_drivers_on)
        else $error("identity code select wrong");
endmodule : touch_adc_control_word
`default_nettype wire

// ---- bench/host_serial_model.sv ----
// host serial port model that shifts control words into the decoder
`default_nettype none
module host_serial_model (
    input  wire logic mclk,
    output var logic  chip_select_n,
    output var logic  serial_clock,
    output var logic  serial_data_in,
    output var int    n_rise,
    output var int    n_fall
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        chip_select_n  = 1'b1;
        serial_clock   = 1'b0;
        serial_data_in = 1'b0;
        n_rise         = 0;
        n_fall         = 0;
    end

    task automatic wait_mclk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_mclk

    // lead zero clocks, word w0, optional overlapped word w1 from clock sp
    task automatic frame(input logic [7:0] w0, input logic [7:0] w1, input int lead,
                         input int sp, input int nclk, input int h);
        int j;
        n_rise        = 0;
        n_fall        = 0;
        chip_select_n = 1'b0;
        wait_mclk(h);
        for (int k = 0; k < lead + nclk; k++) begin
            j = k - lead;
            if (j >= 0 && j < 8) begin
                serial_data_in = w0[7 - j];
            end else if (sp > 0 && j >= sp && j < sp + 8) begin
                serial_data_in = w1[7 - (j - sp)];
            end else begin
                serial_data_in = 1'b0;
            end
            wait_mclk(h);
            serial_clock = 1'b1;
            if (j >= 0) n_rise = n_rise + 1;
            wait_mclk(h);
            serial_clock = 1'b0;
            if (j >= 0) n_fall = n_fall + 1;
        end
        wait_mclk(h);
        chip_select_n  = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask : frame
endmodule : host_serial_model
`default_nettype wire

// ---- bench/touch_adc_control_word_test.sv ----
// self-checking bench for the control word decoder
`default_nettype none
module touch_adc_control_word_test import touch_adc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0] word;
        route_t     exp;
    } row_t;

    logic       mclk, reset, chip_select_n, serial_clock, serial_data_in;
    ctrl_word_t active_config;
    route_t     route;
    logic       word_strobe, powered, tracking, hold_strobe, converting, conversion_done;
    logic       x_drivers_on, y_drivers_on, y_bottom_on, pen_touch_irq_enable;
    int         n_rise, n_fall, n_fail, comparisons, cycles;
    int         t_word, t_power, t_track, t_hold, t_done, t_sleep, n_word, n_done;
    int         t_conv, t_cend;
    logic       x_conv, y_conv;
    logic       prev_upper;
    logic [7:0] w;
    row_t       rows [11] = '{
        '{8'h94, '{SEL_XPOS, 1'b0, 1'b1, 1'b0, 1'b0}},
        '{8'hD9, '{SEL_YPOS, 1'b1, 1'b0, 1'b1, 1'b0}},
        '{8'hA6, '{SEL_AUX3, 1'b0, 1'b0, 1'b0, 1'b0}},
        '{8'hEF, '{SEL_AUX4, 1'b0, 1'b0, 1'b0, 1'b0}},
        '{8'h93, '{SEL_XPOS, 1'b0, 1'b1, 1'b1, 1'b0}},
        '{8'hE0, '{SEL_IDENT, 1'b0, 1'b0, 1'b0, 1'b0}},
        '{8'h84, '{SEL_NONE, 1'b0, 1'b0, 1'b0, 1'b1}},
        '{8'hBE, '{SEL_NONE, 1'b0, 1'b0, 1'b0, 1'b1}},
        '{8'hC5, '{SEL_NONE, 1'b0, 1'b0, 1'b0, 1'b1}},
        '{8'hF4, '{SEL_NONE, 1'b0, 1'b0, 1'b0, 1'b1}},
        '{8'hD4, '{SEL_YPOS, 1'b1, 1'b0, 1'b0, 1'b0}}};

    host_serial_model host (
        .mclk           (mclk),
        .chip_select_n  (chip_select_n),
        .serial_clock   (serial_clock),
        .serial_data_in (serial_data_in),
        .n_rise         (n_rise),
        .n_fall         (n_fall)
    );

    touch_adc_control_word dut (
        .mclk                 (mclk),
        .reset                (reset),
        .chip_select_n        (chip_select_n),
        .serial_clock         (serial_clock),
        .serial_data_in       (serial_data_in),
        .active_config        (active_config),
        .route                (route),
        .word_strobe          (word_strobe),
        .powered              (powered),
        .tracking             (tracking),
        .hold_strobe          (hold_strobe),
        .converting           (converting),
        .conversion_done      (conversion_done),
        .x_drivers_on         (x_drivers_on),
        .y_drivers_on         (y_drivers_on),
        .y_bottom_on          (y_bottom_on),
        .pen_touch_irq_enable (pen_touch_irq_enable)
    );

    always #2 mclk = ~mclk;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic run(input logic [7:0] w0, input logic [7:0] w1, input int lead,
                       input int sp, input int nclk, input int h);
        t_word  = -1;
        t_power = -1;
        t_track = -1;
        t_hold  = -1;
        t_done  = -1;
        t_sleep = -1;
        n_word  = 0;
        n_done  = 0;
        t_conv  = -1;
        t_cend  = -1;
        x_conv  = 1'bx;
        y_conv  = 1'bx;
        host.frame(w0, w1, lead, sp, nclk, h);
        repeat (6) @(posedge mclk);
        #1;
    endtask : run

    task automatic overlap(input logic [7:0] w0, input logic [7:0] w1, input int sp,
                           input int exp_n, input logic [6:0] exp_cfg);
        run(w0, w1, 0, sp, sp + 24, 2);
        check(n_word, exp_n, "overlap words");
        check(active_config[6:0], exp_cfg, "overlap config");
        $display("overlap at %0d done", sp);
    endtask : overlap

    // event timing in serial clock counts, taken from the host model
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (word_strobe === 1'b1) n_word = n_word + 1;
        if (word_strobe === 1'b1 && t_word < 0) t_word = n_rise;
        if ($rose(powered) && t_power < 0) t_power = n_fall;
        if ($fell(powered) && t_sleep < 0) t_sleep = n_fall;
        if ($rose(tracking) && t_track < 0) t_track = n_fall;
        if (hold_strobe === 1'b1 && t_hold < 0) t_hold = n_fall;
        if (conversion_done === 1'b1) n_done = n_done + 1;
        if ($rose(converting) && t_conv < 0) t_conv = n_fall;
        if ($fell(converting) && t_cend < 0) t_cend = n_fall;
        if (hold_strobe === 1'b1) x_conv = x_drivers_on;
        if (hold_strobe === 1'b1) y_conv = y_drivers_on;
        if (conversion_done === 1'b1 && t_done < 0) t_done = n_fall;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    initial begin
        mclk        = 1'b0;
        reset       = 1'b1;
        n_fail      = 0;
        comparisons = 0;
        cycles      = 0;
        prev_upper  = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        reset = 1'b0;
        foreach (rows[i]) begin
            w = rows[i].word;
            run(w, 8'h00, i % 3, 0, 24, (i % 2) ? 5 : 2);
            check(active_config[6:0], w[6:0], "config");
            check(route, rows[i].exp, "route");
            check(t_word, 8, "word end");
            check(t_track, 5, "tracking");
            check(t_hold, 8, "hold");
            check(t_done, w[3] ? 16 : 20, "done");
            check(n_done, 1, "done count");
            check(t_conv, 8, "converting");
            check(t_cend, w[3] ? 16 : 20, "converting end");
            check(x_conv, rows[i].exp.x_drv && !w[2], "x drivers conv");
            check(y_conv, rows[i].exp.y_drv && !w[2], "y drivers conv");
            check(t_power, prev_upper ? -1 : 4, "wake");
            check(t_sleep, w[1] ? -1 : (w[3] ? 16 : 20), "sleep");
            check(powered, w[1], "powered");
            check(pen_touch_irq_enable, !w[0], "pen enable");
            check(y_bottom_on, !w[1] && !w[0], "bottom y");
            check(y_drivers_on, w[1] && w[0] && rows[i].exp.y_drv, "y drivers");
            prev_upper = w[1];
            $display("row %0d done", i);
        end
        overlap(8'h94, 8'hA6, 15, 2, 7'h26);
        overlap(8'h94, 8'h80, 14, 1, 7'h14);
        overlap(8'h9C, 8'hA6, 11, 2, 7'h26);
        overlap(8'h9C, 8'h80, 10, 1, 7'h1C);
        run(8'hE0, 8'h00, 1, 0, 5, 2);
        check(n_word, 0, "aborted word");
        check(active_config[6:0], 7'h1C, "kept config");
        $display("word abort done");
        run(8'h93, 8'h00, 0, 0, 12, 2);
        check(n_word, 1, "word before abort");
        check(n_done, 0, "aborted conversion");
        check(active_config[6:0], 7'h13, "config after abort");
        $display("conversion abort done");
        reset = 1'b1;
        @(posedge mclk);
        #1;
        reset = 1'b0;
        check(active_config, RST_CONFIG, "reset config");
        check(powered, 1'b1, "reset powered");
        check(pen_touch_irq_enable, 1'b1, "reset pen");
        check(route.invalid, 1'b1, "reset route");
        $display("reset done");
        conclude();
    end
endmodule : touch_adc_control_word_test
`default_nettype wire
